// [pkg/sdsr_pkg.sv]
/*
 * Constants, command codes and state encoding for the self-refresh and
 * mode register read block of a low-power DDR SDRAM model.
 * Assumes a single 100 MHz clock and a synchronous active-low reset.
 */
// What the document requires of device and controller
// RULE1 - Self-refresh entry: CKE low, CS low, CA=100
// RULE2 - Controller holds CKE high the cycle before
// RULE3 - No CKE drop during register or data ops
// RULE4 - Two NOPs, then input receivers switch off
// RULE5 - Controller holds CKE low to stay in
// RULE6 - In self-refresh only CKE matters
// RULE7 - One internal refresh soon; internal clock gated
// RULE8 - Controller honours minimum self-refresh residency
// RULE9 - Clock may stop; stable again before exit
// RULE10 - Clock stable two periods before exit edge
// RULE11 - Exit delay holds CKE high, NOPs only
// RULE12 - One refresh between two self-refresh stays
// RULE13 - Self-refresh entry only with banks idle
// RULE14 - Bank mask blocks refresh per bank
// RULE15 - Segment mask blocks refresh per segment
// RULE16 - Reserved mask register writes change nothing
// RULE17 - Mask bit one means masked
// RULE18 - Register read decode and register number
// RULE19 - Register data on low byte, first beat
// RULE20 - Eight-beat read burst, strobes toggle, uninterrupted
// RULE21 - Only NOPs during register read period
// RULE22 - Read/write to register read spacing
// RULE23 - Register read to write spacing
// RULE24 - Extra wait after idle power-down exit
package sdsr_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_NS = 10;                 // Clock period in ns
   localparam int CPDED_CYC = 2;               // NOPs after CKE falls
   localparam int TXSR_NS = 140;               // Exit delay in ns
   localparam int XSR_CYC = (TXSR_NS + CLK_NS - 1) / CLK_NS; // Rounded up
   localparam int RL_CYC = 8;                  // Read latency in cycles
   localparam int MRR_BL = 8;                  // Register read burst length
   localparam logic [4:0] MRR_FIRST = 5'(RL_CYC);              // First beat count
   localparam logic [4:0] MRR_LAST = 5'(RL_CYC + MRR_BL - 1);  // Last beat count

   // ---------------------------------------------------------------
   // Register numbers and reset values
   // ---------------------------------------------------------------
   localparam logic [5:0] MR_BANK_MASK = 6'h10;  // bank_refresh_mask_reg
   localparam logic [5:0] MR_SEG_MASK = 6'h11;   // segment_refresh_mask_reg
   localparam logic [5:0] MR_RSVD_MASK = 6'h12;  // Reserved mask register
   localparam logic [5:0] MR_CAL_A = 6'h20;      // calib_pattern_a_reg
   localparam logic [5:0] MR_CAL_B = 6'h28;      // calib_pattern_b_reg
   localparam logic [7:0] MASK_RST = 8'h00;      // Masks reset to all refreshed

   // ---------------------------------------------------------------
   // Command codes on CA3..CA0 at the rising edge, with care bits
   // ---------------------------------------------------------------
   localparam logic [3:0] CMD_SRE = 4'h4;       // CA2 high, CA1/CA0 low
   localparam logic [3:0] CARE_SRE = 4'h7;      // CA3 is not part of it
   localparam logic [3:0] CMD_MRR = 4'h8;       // CA3 high, CA2..CA0 low
   localparam logic [3:0] CMD_MRW = 4'h0;       // CA3..CA0 all low
   localparam logic [3:0] CARE_MR = 4'hf;

   // Power state of the device
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_CPDED = 4'b0010,
      ST_SR    = 4'b0100,
      ST_XSR   = 4'b1000
   } sdsr_state_e;
endpackage

// [rtl/sdsr_mr_mem.sv]
/*
 * Mode register storage: 64 words of 8 bits, one write port and one
 * registered read port. Assumes the writer filters reserved numbers.
 */
`timescale 1ns/1ps
module sdsr_mr_mem
#(
   parameter int AW = 6,
   parameter int DW = 8
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   logic [DW-1:0] mem_r [2**AW];   // Register array

   // Write and registered read; reset clears so reads never return X
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < 2**AW; i++)
         begin
            mem_r[i] <= '0;
         end
         rdata <= '0;
      end
      else
      begin
         if (we)
         begin
            mem_r[waddr] <= wdata;
         end
         rdata <= mem_r[raddr];
      end
   end
endmodule

// [rtl/sdsr_core.sv]
/*
 * Device-side command logic for self-refresh entry, residency and exit,
 * partial array retention masks and the mode register read burst.
 * Assumes pins arrive asynchronously and pass two flops before use;
 * one DQ beat is produced per clock in this single-rate model.
 */
`timescale 1ns/1ps
module sdsr_core
   import sdsr_pkg::*;
#(
   parameter int SR_REF_CYC = 256,          // Internal refresh interval in self-refresh
   parameter logic [7:0] CAL_PAT_A = 8'h55, // Pattern A, plain default
   parameter logic [7:0] CAL_PAT_B = 8'h33  // Pattern B, plain default
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic [9:0] ca_r,
   input wire logic [9:0] ca_f,
   output logic sr_active,
   output logic rx_en,
   output logic iclk_en,
   output logic ref_pulse,
   output logic [7:0] ref_bank_en,
   output logic [7:0] ref_seg_en,
   output logic [15:0] dq_out,
   output logic dq_oe,
   output logic dqs_out,
   output logic dqs_oe
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      sdsr_state_e st;            // Power state
      logic [1:0] cke_sy;         // CKE synchroniser
      logic [1:0] csn_sy;         // Chip select synchroniser
      logic [1:0][9:0] car_sy;    // Rising-half CA synchroniser
      logic [1:0][9:0] caf_sy;    // Falling-half CA synchroniser
      logic cke_q;                // CKE one cycle ago
      logic [15:0] tmr;           // Shared down-counter
      logic [7:0] bank_mask;      // Copy of bank mask
      logic [7:0] seg_mask;       // Copy of segment mask
      logic mrr_busy;             // Register read in flight
      logic [4:0] mrr_cnt;        // Cycles since register read
      logic [5:0] mrr_addr;       // Register being read
      logic mem_we;               // Storage write strobe
      logic [5:0] mem_waddr;
      logic [7:0] mem_wdata;
      logic sr_active;
      logic rx_en;
      logic iclk_en;
      logic ref_pulse;
      logic [7:0] ref_bank_en;
      logic [7:0] ref_seg_en;
      logic [15:0] dq_out;
      logic dq_oe;
      logic dqs_out;
      logic dqs_oe;
   } sdsr_reg_s;

   sdsr_reg_s r_r;                // Registered state
   sdsr_reg_s r_nxt;              // Next state
   logic [7:0] mem_rdata;         // Stored register value
   logic cmd_ok;                  // Synced CS low with CKE high the cycle before, in the idle state
   logic sre_hit;                 // Self-refresh entry decoded
   logic mrr_hit;                 // Register read decoded
   logic mrw_hit;                 // Register write decoded
   logic [5:0] mr_num;            // Register number from both halves
   logic mr_hi;                   // Register number beyond the stored range
   logic [2:0] beat;              // Burst beat index
   logic pat_bit;                 // Calibration bit for this beat

   // Command compare on CA3..CA0 with a care mask
   function automatic logic cmd_match(input logic [3:0] ca, input logic [3:0] code,
                                      input logic [3:0] care);
      cmd_match = ((ca ^ code) & care) == 4'h0;
   endfunction

   // ---------------------------------------------------------------
   // Decode, only in the idle state so that self-refresh ignores CA
   // ---------------------------------------------------------------
   assign cmd_ok = !r_r.csn_sy[1] && r_r.cke_q && r_r.st == ST_IDLE; // see RULE6
   // Entry needs CKE low now and high in the previous cycle
   assign sre_hit = !r_r.cke_sy[1] && cmd_ok
                    && cmd_match(r_r.car_sy[1][3:0], CMD_SRE, CARE_SRE); // see RULE1
   assign mrr_hit = r_r.cke_sy[1] && cmd_ok
                    && cmd_match(r_r.car_sy[1][3:0], CMD_MRR, CARE_MR); // see RULE18
   assign mrw_hit = r_r.cke_sy[1] && cmd_ok
                    && cmd_match(r_r.car_sy[1][3:0], CMD_MRW, CARE_MR);
   // Only 64 registers exist; the top two number bits are looked at apart
   assign mr_num = {r_r.car_sy[1][7:4], r_r.caf_sy[1][1:0]}; // see RULE18
   assign mr_hi = |r_r.car_sy[1][9:8];

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb
   begin
      r_nxt = r_r;
      beat = 3'h0;
      pat_bit = 1'b0;
      // First flops feed only the second flops
      r_nxt.cke_sy = {r_r.cke_sy[0], cke};
      r_nxt.csn_sy = {r_r.csn_sy[0], cs_n};
      r_nxt.car_sy = {r_r.car_sy[0], ca_r};
      r_nxt.caf_sy = {r_r.caf_sy[0], ca_f};
      r_nxt.cke_q = r_r.cke_sy[1];
      r_nxt.ref_pulse = 1'b0;
      r_nxt.mem_we = 1'b0;
      case (r_r.st)
         ST_IDLE:
         begin
            // Entry: receivers stay on through the NOP period
            if (sre_hit)
            begin
               r_nxt.st = ST_CPDED;
               r_nxt.tmr = 16'(CPDED_CYC - 1); // see RULE4
            end
         end
         ST_CPDED:
         begin
            if (r_r.tmr != 16'h0)
            begin
               r_nxt.tmr = r_r.tmr - 16'h1;
            end
            else
            begin
               // Period over: receivers and internal clock off, refresh at once
               r_nxt.st = ST_SR;
               r_nxt.rx_en = 1'b0; // see RULE4
               r_nxt.iclk_en = 1'b0; // see RULE7
               r_nxt.sr_active = 1'b1;
               r_nxt.ref_pulse = 1'b1; // see RULE7
               r_nxt.tmr = 16'(SR_REF_CYC - 1);
            end
         end
         ST_SR:
         begin
            // Only CKE is looked at here
            if (r_r.cke_sy[1])
            begin
               r_nxt.st = ST_XSR;
               r_nxt.rx_en = 1'b1;
               r_nxt.iclk_en = 1'b1;
               r_nxt.tmr = 16'(XSR_CYC - 1);
            end
            else if (r_r.tmr == 16'h0)
            begin
               // Internal timer counts input clock cycles to keep the array alive
               r_nxt.ref_pulse = 1'b1; // see RULE6
               r_nxt.tmr = 16'(SR_REF_CYC - 1);
            end
            else
            begin
               r_nxt.tmr = r_r.tmr - 16'h1;
            end
         end
         ST_XSR:
         begin
            // Commands during the exit delay are not decoded
            if (r_r.tmr == 16'h0)
            begin
               r_nxt.st = ST_IDLE;
               r_nxt.sr_active = 1'b0;
            end
            else
            begin
               r_nxt.tmr = r_r.tmr - 16'h1;
            end
         end
         default:
         begin
            r_nxt.st = ST_IDLE;
         end
      endcase

      // Mask bits of one mean masked; refresh enables are their inverse
      r_nxt.ref_bank_en = ~r_r.bank_mask; // see RULE14 see RULE17
      r_nxt.ref_seg_en = ~r_r.seg_mask; // see RULE15 see RULE17

      // Register write: reserved and out-of-range numbers are dropped entirely
      if (mrw_hit && !mr_hi && mr_num != MR_RSVD_MASK) // see RULE16
      begin
         r_nxt.mem_we = 1'b1;
         r_nxt.mem_waddr = mr_num;
         r_nxt.mem_wdata = r_r.caf_sy[1][9:2];
         if (mr_num == MR_BANK_MASK)
         begin
            r_nxt.bank_mask = r_r.caf_sy[1][9:2]; // see RULE14
         end
         if (mr_num == MR_SEG_MASK)
         begin
            r_nxt.seg_mask = r_r.caf_sy[1][9:2]; // see RULE15
         end
      end

      // Register read burst; a new read is ignored while one runs
      if (r_r.mrr_busy)
      begin
         if (r_r.mrr_cnt == MRR_LAST)
         begin
            r_nxt.mrr_busy = 1'b0;
            r_nxt.mrr_cnt = 5'h0;
         end
         else
         begin
            r_nxt.mrr_cnt = r_r.mrr_cnt + 5'h1; // see RULE20
         end
      end
      else if (mrr_hit)
      begin
         r_nxt.mrr_busy = 1'b1;
         r_nxt.mrr_cnt = 5'h1;
         // Out-of-range reads fetch the never-written reserved word, so no aliasing
         r_nxt.mrr_addr = mr_hi ? MR_RSVD_MASK : mr_num;
      end

      // Data and strobe for the coming cycle
      r_nxt.dq_oe = r_nxt.mrr_busy && r_nxt.mrr_cnt >= MRR_FIRST;
      r_nxt.dqs_oe = r_nxt.dq_oe;
      r_nxt.dqs_out = r_nxt.dq_oe ? ~r_r.dqs_out : 1'b0; // see RULE20
      r_nxt.dq_out = 16'h0;
      if (r_nxt.dq_oe)
      begin
         beat = 3'(r_nxt.mrr_cnt - MRR_FIRST);
         if (r_r.mrr_addr == MR_CAL_A || r_r.mrr_addr == MR_CAL_B)
         begin
            // Pattern bit copied onto every lane, all beats meaningful
            pat_bit = (r_r.mrr_addr == MR_CAL_A) ? CAL_PAT_A[beat] : CAL_PAT_B[beat];
            r_nxt.dq_out = {16{pat_bit}};
         end
         else if (beat == 3'h0)
         begin
            // Upper lanes and later beats are driven low as their value is free
            r_nxt.dq_out = {8'h00, mem_rdata}; // see RULE19
         end
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         // Chip select synchroniser starts deselected, its idle level
         r_r <= '{st: ST_IDLE, csn_sy: 2'b11, bank_mask: MASK_RST, seg_mask: MASK_RST,
                  rx_en: 1'b1, iclk_en: 1'b1, ref_bank_en: 8'hff,
                  ref_seg_en: 8'hff, default: '0};
      end
      else
      begin
         r_r <= r_nxt;
      end
   end

   // Register storage for read-back
   sdsr_mr_mem #(.AW(6), .DW(8)) u_mem (
      .clk(clk),
      .rst_n(rst_n),
      .we(r_r.mem_we),
      .waddr(r_r.mem_waddr),
      .wdata(r_r.mem_wdata),
      .raddr(r_r.mrr_addr),
      .rdata(mem_rdata)
   );

   // ---------------------------------------------------------------
   // Outputs straight from the state flops
   // ---------------------------------------------------------------
   assign sr_active = r_r.sr_active;
   assign rx_en = r_r.rx_en;
   assign iclk_en = r_r.iclk_en;
   assign ref_pulse = r_r.ref_pulse;
   assign ref_bank_en = r_r.ref_bank_en;
   assign ref_seg_en = r_r.ref_seg_en;
   assign dq_out = r_r.dq_out;
   assign dq_oe = r_r.dq_oe;
   assign dqs_out = r_r.dqs_out;
   assign dqs_oe = r_r.dqs_oe;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   localparam int A_RL = RL_CYC;  // Read latency for checks

   property p_sre_state;
      @(posedge clk) disable iff (!rst_n) sre_hit |=> r_r.st == ST_CPDED;
   endproperty
   a_sre_state: assert property (p_sre_state) else $error("entry not taken"); // see RULE1

   property p_cpded;
      @(posedge clk) disable iff (!rst_n) sre_hit |=> rx_en ##1 rx_en ##1 !rx_en;
   endproperty
   a_cpded: assert property (p_cpded) else $error("receivers off at wrong cycle"); // see RULE4

   property p_sr_ignore;
      @(posedge clk) disable iff (!rst_n)
         r_r.st != ST_IDLE |=> $stable(r_r.bank_mask) && !r_r.mem_we && !$rose(r_r.mrr_busy);
   endproperty
   a_sr_ignore: assert property (p_sr_ignore) else $error("command taken in low power"); // see RULE6

   property p_first_ref;
      @(posedge clk) disable iff (!rst_n)
         $rose(r_r.st == ST_SR) |-> ref_pulse && !iclk_en;
   endproperty
   a_first_ref: assert property (p_first_ref) else $error("no refresh at entry"); // see RULE7

   property p_bank_en;
      @(posedge clk) disable iff (!rst_n)
         ref_pulse |-> ref_bank_en == ~$past(r_r.bank_mask);
   endproperty
   a_bank_en: assert property (p_bank_en) else $error("bank enables wrong"); // see RULE14

   property p_seg_en;
      @(posedge clk) disable iff (!rst_n)
         ref_pulse |-> ref_seg_en == ~$past(r_r.seg_mask);
   endproperty
   a_seg_en: assert property (p_seg_en) else $error("segment enables wrong"); // see RULE15

   property p_rsvd;
      @(posedge clk) disable iff (!rst_n)
         mrw_hit && mr_num == MR_RSVD_MASK |=>
            !r_r.mem_we && $stable(r_r.bank_mask) && $stable(r_r.seg_mask);
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved write had effect"); // see RULE16

   property p_mrr_lat;
      @(posedge clk) disable iff (!rst_n)
         mrr_hit && !r_r.mrr_busy |-> !dq_oe ##A_RL dq_oe;
   endproperty
   a_mrr_lat: assert property (p_mrr_lat) else $error("read latency wrong"); // see RULE19

   property p_burst;
      @(posedge clk) disable iff (!rst_n) $rose(dq_oe) |-> dq_oe [*8] ##1 !dq_oe;
   endproperty
   a_burst: assert property (p_burst) else $error("burst not eight beats"); // see RULE20

   property p_dqs;
      @(posedge clk) disable iff (!rst_n) dq_oe && $past(dq_oe) |-> dqs_out != $past(dqs_out);
   endproperty
   a_dqs: assert property (p_dqs) else $error("strobe not toggling"); // see RULE20

   c_sr_exit: cover property (@(posedge clk) disable iff (!rst_n)
      $fell(sr_active));
   c_sr_ref: cover property (@(posedge clk) disable iff (!rst_n)
      r_r.st == ST_SR && ref_pulse && $past(r_r.st == ST_SR));
   c_mrr: cover property (@(posedge clk) disable iff (!rst_n) $fell(dq_oe));
endmodule

// [verification/sdsr_ctrl_model.sv]
/*
 * Memory controller model: drives clock enable, chip select and CA pins.
 * Assumes one caller at a time and a free-running, always stable clock.
 */
`timescale 1ns/1ps
module sdsr_ctrl_model
   import sdsr_pkg::*;
(
   input wire logic clk,
   output logic cke,
   output logic cs_n,
   output logic [9:0] ca_r,
   output logic [9:0] ca_f
);
   // ---------------------------------------------------------------
   // Pin drivers
   // ---------------------------------------------------------------
   // Clock never stops here, so it is stable long before any exit
   initial
   begin
      cke = 1'b1;
      cs_n = 1'b1;
      ca_r = 10'h000;
      ca_f = 10'h3ff;
   end

   // One command cycle, launched just after the edge
   task automatic drive(input logic k, input logic cs, input logic [9:0] r,
                        input logic [9:0] f);
      @(posedge clk);
      cke <= k;
      cs_n <= cs;
      ca_r <= r;
      ca_f <= f;
   endtask

   // Deselected cycles: CA keeps flipping so stale bits never look held
   task automatic nop(input int n);
      repeat (n) drive(cke, 1'b1, ~ca_r, ~ca_f);
   endtask

   // Register write; no reads or writes exist here, so no spacing is owed
   task automatic mrw(input logic [7:0] num, input logic [7:0] d);
      drive(1'b1, 1'b0, {num[7:2], CMD_MRW}, {d, num[1:0]});
      nop(6);
   endtask

   // Register read; a short gap is only used to provoke a refusal
   task automatic mrr(input logic [7:0] num, input int gap);
      drive(1'b1, 1'b0, {num[7:2], CMD_MRR}, {~ca_f[9:2], num[1:0]});
      nop(gap);
   endtask

   // Entry only after bursts end and with banks never opened
   task automatic sr_enter();
      nop(1);
      drive(1'b0, 1'b0, {6'h00, CMD_SRE}, ~ca_f);
      repeat (CPDED_CYC) drive(1'b0, 1'b1, ~ca_r, ~ca_f);
   endtask

   // Residency length is set by the caller; one stay per run, no refresh owed
   task automatic sr_exit();
      repeat (XSR_CYC + 6) drive(1'b1, 1'b1, ~ca_r, ~ca_f);
   endtask
endmodule

// [verification/tb_top.sv]
/*
 * Self-checking bench for the self-refresh and register read block.
 * Assumes the controller model above; read beats are scored from a queue.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_count++; $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module tb_top;
   import sdsr_pkg::*;
   localparam int REF_CYC = 8;            // Short refresh interval keeps runs brief
   localparam logic [7:0] PAT_A = 8'h96;  // Asymmetric so bit order shows
   localparam logic [7:0] PAT_B = 8'h3c;
   logic clk, rst_n, cke, cs_n, sr_active, rx_en, iclk_en, ref_pulse;
   logic dq_oe, dqs_out, dqs_oe;
   logic [9:0] ca_r, ca_f;
   logic [7:0] ref_bank_en, ref_seg_en, bm, sm;
   logic [15:0] dq_out;
   logic [16:0] exp_q[$];  // Expected {strobe, data} per read beat
   logic [16:0] got;
   int err_count, n_compared, seed, n, np;

   // ---------------------------------------------------------------
   // Clock, design and controller
   // ---------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   sdsr_core #(.SR_REF_CYC(REF_CYC), .CAL_PAT_A(PAT_A), .CAL_PAT_B(PAT_B)) i_sdsr_core (
      .clk(clk), .rst_n(rst_n), .cke(cke), .cs_n(cs_n), .ca_r(ca_r), .ca_f(ca_f),
      .sr_active(sr_active), .rx_en(rx_en), .iclk_en(iclk_en), .ref_pulse(ref_pulse),
      .ref_bank_en(ref_bank_en), .ref_seg_en(ref_seg_en), .dq_out(dq_out),
      .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe));

   sdsr_ctrl_model u_ctrl (.clk(clk), .cke(cke), .cs_n(cs_n), .ca_r(ca_r), .ca_f(ca_f));

   // ---------------------------------------------------------------
   // Scoreboard and helpers
   // ---------------------------------------------------------------
   // Every driven beat takes the oldest note; a beat with no note is an error
   always @(posedge clk)
   begin
      if (dq_oe === 1'b1)
      begin
         if (exp_q.size() == 0)
            `CHK("extra_beat", 1'b0, 1'b1)
         else
         begin
            got = exp_q.pop_front();
            `CHK("beat", got, {dqs_out, dq_out})
            `CHK("dqs_oe", 1'b1, dqs_oe)
         end
      end
   end

   // Notes the eight beats of one read; pattern bit b repeats on all lanes
   task automatic push(input logic [7:0] b0, input logic cal, input logic [7:0] pat);
      logic [15:0] d;
      for (int b = 0; b < MRR_BL; b++)
      begin
         d = cal ? {16{pat[b]}} : ((b == 0) ? {8'h00, b0} : 16'h0000);
         exp_q.push_back({~b[0], d});
      end
   endtask

   task automatic rd(input logic [7:0] num, input logic [7:0] b0, input logic cal,
                     input logic [7:0] pat);
      push(b0, cal, pat);
      u_ctrl.mrr(num, RL_CYC + MRR_BL + 4);
      `CHK("beats_left", 0, exp_q.size())
   endtask

   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
      begin
         $display("Simulation passed");
      end
      else
      begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // A hang is cut short well past the few hundred cycles needed
   initial
   begin
      repeat (3000) @(posedge clk);
      err_count++;
      stop_test();
   end

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial
   begin
      seed = 78276;
      err_count = 0;
      n_compared = 0;
      rst_n = 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      `CHK("sr_rst", 1'b0, sr_active)
      `CHK("rx_rst", 1'b1, rx_en)
      `CHK("iclk_rst", 1'b1, iclk_en)
      `CHK("bank_rst", 8'hff, ref_bank_en)
      `CHK("seg_rst", 8'hff, ref_seg_en)
      // Random masks, then a reserved write that must not disturb them
      bm = 8'($random(seed));
      sm = 8'($random(seed));
      u_ctrl.mrw(8'(MR_BANK_MASK), bm);
      u_ctrl.mrw(8'(MR_SEG_MASK), sm);
      u_ctrl.mrw(8'(MR_RSVD_MASK), 8'($random(seed)));
      #1;
      `CHK("bank_en", ~bm, ref_bank_en)
      `CHK("seg_en", ~sm, ref_seg_en)
      rd(8'(MR_BANK_MASK), bm, 1'b0, 8'h00);
      rd(8'(MR_SEG_MASK), sm, 1'b0, 8'h00);
      rd(8'(MR_CAL_A), 8'h00, 1'b1, PAT_A);
      rd(8'(MR_CAL_B), 8'h00, 1'b1, PAT_B);
      // A second read while the first is busy is dropped
      push(sm, 1'b0, 8'h00);
      u_ctrl.mrr(8'(MR_SEG_MASK), 2);
      u_ctrl.mrr(8'(MR_BANK_MASK), RL_CYC + MRR_BL + 6);
      `CHK("busy_left", 0, exp_q.size())
      // Entry: receivers stay on through the NOP period
      fork
         u_ctrl.sr_enter();
         begin
            repeat (6) @(posedge clk);
            #1;
            `CHK("rx_nop", 1'b1, rx_en)
         end
      join
      n = 0;
      while (rx_en !== 1'b0 && n < 6)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      `CHK("iclk_off", 1'b0, iclk_en)
      `CHK("sr_on", 1'b1, sr_active)
      `CHK("ref_first", 1'b1, ref_pulse)
      // Residency: random pins are ignored, refresh keeps its pace
      np = 0;
      repeat (4 * REF_CYC)
      begin
         n = $random(seed);
         u_ctrl.drive(1'b0, n[20], n[9:0], n[19:10]);
         #1;
         if (ref_pulse === 1'b1)
            np++;
         `CHK("rx_off", 1'b0, rx_en)
      end
      `CHK("ref_count", 4, np)
      // Exit: receivers back, then the exit delay runs out
      fork
         u_ctrl.sr_exit();
         begin
            n = 0;
            while (rx_en !== 1'b1 && n < 8)
            begin
               @(posedge clk);
               #1;
               n++;
            end
            `CHK("iclk_on", 1'b1, iclk_en)
            n = 0;
            while (sr_active === 1'b1 && n < 30)
            begin
               @(posedge clk);
               #1;
               n++;
            end
            `CHK("exit_len", XSR_CYC, n)
         end
      join
      rd(8'(MR_BANK_MASK), bm, 1'b0, 8'h00);
      stop_test();
   end
endmodule
